/* File: hdl/sipc_pkg.sv */
// package: constants, timing and carrier types for the idle power controller
package sipc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 100;
  // idle interval before shutdown, seconds
  localparam int unsigned IDLE_S = 30;
  // line-valid fall delay (ns), rise delay (ns)
  localparam int unsigned VALID_FALL_NS = 30_000;
  localparam int unsigned VALID_RISE_NS = 400;
  // wake to driver enable delay (ns), rail recovery delay (ns)
  localparam int unsigned WAKE_NS = 100_000;
  localparam int unsigned PUMP_NS = 50_000;
  // derived cycle counts (all are "about" figures, rounded down)
  localparam int unsigned IDLE_CYC = IDLE_S * CLK_HZ;
  localparam int unsigned VALID_FALL_CYC = VALID_FALL_NS / CLK_NS;
  localparam int unsigned VALID_RISE_CYC = VALID_RISE_NS / CLK_NS;
  localparam int unsigned WAKE_CYC = WAKE_NS / CLK_NS;
  localparam int unsigned PUMP_CYC = PUMP_NS / CLK_NS;

  // ---------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ = 4'h8;
  localparam logic [3:0] REG_MASK = 4'hC;
  // status / irq bit positions
  localparam int unsigned BIT_AWAKE = 0;
  localparam int unsigned BIT_VALID = 1;
  localparam int unsigned BIT_READY = 2;
  localparam int unsigned BIT_ACT = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic [31:0] WB_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,  // charge pump off, drivers high impedance
    ST_WAKE = 4'b0010, // pump restarting, drivers still off
    ST_ON = 4'b0100,   // drivers active, rails good
    ST_RST = 4'b1000   // state right after reset
  } sipc_state_t;

  // control pins grouped
  typedef struct packed {
    logic auto_wake_select;
    logic force_sleep_pin;
  } sipc_ctrl_t;

endpackage

/* File: hdl/sipc_top.sv */
// module: serial transceiver idle power controller, wishbone status port
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Notes on behaviour
// - wake-select low, sleep-force high: automatic mode
// - sleep-force low always forces shutdown
// - collapsed receiver levels drive line-valid low
// - line-valid reflects receiver level above threshold
// - thirty seconds without transitions enters low power
// - any input transition wakes in automatic mode
// - idle shutdown happens despite valid line levels
// - line-valid never feeds the idle decision internally
// - line-valid on wake-select keeps device awake
// - line-valid on both pins follows line level
// - ready high once negative rail is good
// - shutdown stops pumps; rails return after 50 us
// - line-valid falls 30 us, rises 0.4 us
// - offline after 30 s, drivers enabled 100 us after wake
// - receiver outputs stay active in all states
// ---------------------------------------------------------------
module sipc_top
  import sipc_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned N_DRV = 2,
  parameter int unsigned N_RCV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic auto_wake_select_i,
  input wire logic force_sleep_pin_i,
  input wire logic [N_DRV-1:0] drv_in_i,
  input wire logic [N_RCV-1:0] rcv_in_i,
  input wire logic [N_RCV-1:0] rcv_level_ok_i,
  input wire logic neg_rail_ok_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [N_DRV-1:0] drv_out_o,
  output logic [N_DRV-1:0] drv_oe_o,
  output logic [N_RCV-1:0] rcv_out_o,
  output logic line_valid_o,
  output logic ready_o,
  output logic pump_en_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // activity detection
  // ---------------------------------------------------------------
  localparam int unsigned NIN = N_DRV + N_RCV;
  logic [NIN-1:0] in_prev_q, in_prev_d;  // last sampled inputs
  logic act_q, act_d;                     // transition seen this cycle
  logic [NIN-1:0] in_now;

  always_comb begin
    in_now = {drv_in_i, rcv_in_i};
    in_prev_d = in_now;
    // line-valid is deliberately not part of the activity term
    act_d = |(in_now ^ in_prev_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // track the pins during reset so release shows no false edge
      in_prev_q <= in_prev_d;
      act_q <= 1'b0;
    end else begin
      in_prev_q <= in_prev_d;
      act_q <= act_d;
    end
  end

  // ---------------------------------------------------------------
  // idle timer
  // ---------------------------------------------------------------
  logic [31:0] idle_cnt_q, idle_cnt_d;  // cycles since last transition
  logic idle_q, idle_d;                 // idle interval elapsed

  always_comb begin
    idle_cnt_d = idle_cnt_q;
    idle_d = idle_q;
    if (act_q) begin
      idle_cnt_d = '0;
      idle_d = 1'b0;
    end else if (idle_cnt_q >= 32'(IDLE_CYCLES - 1)) begin
      idle_d = 1'b1;
    end else begin
      idle_cnt_d = idle_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_q <= '0;
      idle_q <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_d;
      idle_q <= idle_d;
    end
  end

  // ---------------------------------------------------------------
  // line-valid filter with asymmetric delays
  // ---------------------------------------------------------------
  logic valid_q, valid_d;            // filtered line-valid
  logic [15:0] vcnt_q, vcnt_d;       // dwell counter
  logic lvl_any;

  always_comb begin
    // any receiver beyond threshold counts as a live line
    lvl_any = |rcv_level_ok_i;
    valid_d = valid_q;
    vcnt_d = '0;
    if (lvl_any != valid_q) begin
      vcnt_d = vcnt_q + 16'h0001;
      if (valid_q && vcnt_q >= 16'(VALID_FALL_CYC - 1)) begin
        valid_d = 1'b0;
        vcnt_d = '0;
      end else if (!valid_q && vcnt_q >= 16'(VALID_RISE_CYC - 1)) begin
        valid_d = 1'b1;
        vcnt_d = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      vcnt_q <= '0;
    end else begin
      valid_q <= valid_d;
      vcnt_q <= vcnt_d;
    end
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  sipc_state_t st_q, st_d;
  logic [15:0] wcnt_q, wcnt_d;  // wake delay counter
  logic pump_q, pump_d;
  logic want_on;
  sipc_ctrl_t ctl;

  always_comb begin
    ctl = '{auto_wake_select: auto_wake_select_i,
            force_sleep_pin: force_sleep_pin_i};
    // line-valid only matters when wired back to these pins
    if (!ctl.force_sleep_pin) begin
      want_on = 1'b0;
    end else if (ctl.auto_wake_select) begin
      want_on = 1'b1;
    end else begin
      want_on = !idle_q || act_q;
    end
    st_d = st_q;
    wcnt_d = '0;
    pump_d = pump_q;
    case (st_q)
      ST_RST: begin
        st_d = ST_WAKE;
        pump_d = 1'b1;
      end
      ST_OFF: begin
        pump_d = 1'b0;
        if (want_on) begin
          st_d = ST_WAKE;
          pump_d = 1'b1;
        end
      end
      ST_WAKE: begin
        wcnt_d = wcnt_q + 16'h0001;
        if (!want_on) begin
          st_d = ST_OFF;
          pump_d = 1'b0;
        end else if (wcnt_q >= 16'(WAKE_CYC - 1)) begin
          st_d = ST_ON;
        end
      end
      ST_ON: begin
        if (!want_on) begin
          st_d = ST_OFF;
          pump_d = 1'b0;
        end
      end
      default: begin
        st_d = ST_OFF;
        pump_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_RST;
      wcnt_q <= '0;
      pump_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      pump_q <= pump_d;
    end
  end

  // ---------------------------------------------------------------
  // pin outputs, all registered
  // ---------------------------------------------------------------
  logic [N_DRV-1:0] dout_q, dout_d, doe_q, doe_d;
  logic [N_RCV-1:0] rout_q, rout_d;
  logic rdy_q, rdy_d;

  always_comb begin
    // drivers pass inverted data; enabled only when the next state is ST_ON
    dout_d = ~drv_in_i;
    doe_d = (st_d == ST_ON) ? '1 : '0;
    rout_d = ~rcv_in_i;
    rdy_d = pump_d && neg_rail_ok_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_q <= '0;
      doe_q <= '0;
      rout_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      doe_q <= doe_d;
      rout_q <= rout_d;
      rdy_q <= rdy_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and wishbone slave
  // ---------------------------------------------------------------
  logic [EV_W-1:0] irq_st_q, irq_st_d, mask_q, mask_d, ev;
  logic ack_q, ack_d, irq_q, irq_d;
  logic [31:0] dat_q, dat_d;
  logic [EV_W-1:0] stat_now;
  logic acc;

  always_comb begin
    stat_now = {act_q, rdy_q, valid_q, (st_q == ST_ON)};
    // events: changes of awake, valid, ready; plus any activity
    ev = {act_q, rdy_d ^ rdy_q, valid_d ^ valid_q,
          (st_d == ST_ON) ^ (st_q == ST_ON)};
    acc = wb_cyc_i && wb_stb_i && !ack_q;
    ack_d = acc;
    dat_d = dat_q;
    mask_d = mask_q;
    irq_st_d = irq_st_q;
    if (acc) begin
      dat_d = WB_ZERO;
      if (wb_adr_i == REG_CTRL) begin
        dat_d[1:0] = {force_sleep_pin_i, auto_wake_select_i};
      end else if (wb_adr_i == REG_STAT) begin
        dat_d[EV_W-1:0] = stat_now;
      end else if (wb_adr_i == REG_IRQ) begin
        dat_d[EV_W-1:0] = irq_st_q;
        if (!wb_we_i) begin
          irq_st_d = '0;  // read clears
        end
      end else if (wb_adr_i == REG_MASK) begin
        dat_d[EV_W-1:0] = mask_q;
        if (wb_we_i && wb_sel_i[0]) begin
          mask_d = wb_dat_i[EV_W-1:0];
        end
      end
    end
    // a new event wins over a same-cycle read clear
    irq_st_d = irq_st_d | ev;
    irq_d = |(irq_st_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
      mask_q <= MASK_RST;
      ack_q <= 1'b0;
      dat_q <= WB_ZERO;
      irq_q <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_q <= irq_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign drv_out_o = dout_q;
  assign drv_oe_o = doe_q;
  assign rcv_out_o = rout_q;
  assign line_valid_o = valid_q;
  assign ready_o = rdy_q;
  assign pump_en_o = pump_q;
  assign irq_o = irq_q;

endmodule

/* File: tb/sipc_monitor.sv */
// checker: port assertions for the idle power controller
`timescale 1ns/1ps
module sipc_monitor
  import sipc_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned N_DRV = 2,
  parameter int unsigned N_RCV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic auto_wake_select_i,
  input wire logic force_sleep_pin_i,
  input wire logic [N_DRV-1:0] drv_in_i,
  input wire logic [N_RCV-1:0] rcv_in_i,
  input wire logic [N_RCV-1:0] rcv_level_ok_i,
  input wire logic neg_rail_ok_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [N_DRV-1:0] drv_oe_o,
  input wire logic [N_RCV-1:0] rcv_out_o,
  input wire logic line_valid_o,
  input wire logic ready_o,
  input wire logic pump_en_o
);
  localparam int WK = 1010; // forced-on settle time plus slack
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------
  // helper counters: idle, level lost, forced on
  // ------------------------------------------------
  logic [31:0] idle_q, lost_q, on_q;
  logic [N_DRV+N_RCV-1:0] in_q;
  logic auto_m, on_m, chg;
  assign auto_m = !auto_wake_select_i && force_sleep_pin_i;
  assign on_m = auto_wake_select_i && force_sleep_pin_i;
  assign chg = {drv_in_i, rcv_in_i} != in_q;
  always_ff @(posedge clk_i) begin
    in_q <= {drv_in_i, rcv_in_i};
    idle_q <= (rst_i || chg || !auto_m) ? '0 : idle_q + 1;
    lost_q <= (rst_i || |rcv_level_ok_i) ? '0 : lost_q + 1;
    on_q <= (rst_i || !on_m) ? '0 : on_q + 1;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // pump restarts within a few cycles of a qualifying edge
  sequence s_pump_up;
    ##[1:3] pump_en_o;
  endsequence
  AST_WB_ACK:
    assert property (s_req |=> s_ack) else $error("bad ack");
  AST_FORCE_OFF:
    assert property (!force_sleep_pin_i [*4] |-> ~|drv_oe_o && !pump_en_o)
    else $error("sleep pin ignored");
  AST_RCV_LIVE:
    assert property (!$past(rst_i) |-> rcv_out_o == ~$past(rcv_in_i))
    else $error("receiver stalled");
  AST_VALID_LOW:
    assert property (lost_q > 305 |-> !line_valid_o)
    else $error("line valid stuck");
  AST_VALID_HOLD:
    assert property (lost_q inside {[1:290]} && $past(line_valid_o)
      |-> line_valid_o) else $error("line valid fell early");
  AST_VALID_UP:
    assert property ((|rcv_level_ok_i) [*8] |-> line_valid_o)
    else $error("line valid late");
  AST_READY_RAIL:
    assert property (ready_o |-> $past(neg_rail_ok_i))
    else $error("ready without rail");
  AST_READY_UP:
    assert property ((neg_rail_ok_i && pump_en_o) [*2] |-> ready_o)
    else $error("ready missing");
  AST_IDLE_OFF:
    assert property (idle_q > IDLE_CYCLES + 4 |-> ~|drv_oe_o && !pump_en_o)
    else $error("no idle shutdown");
  AST_WAKE:
    assert property (auto_m && chg && !$past(rst_i) |->
      s_pump_up ##[1:1000] &drv_oe_o)
    else $error("no wake");
  AST_FORCED_ON:
    assert property (on_q > WK |-> &drv_oe_o && pump_en_o)
    else $error("forced on failed");
endmodule
bind sipc_top sipc_monitor #(.IDLE_CYCLES(IDLE_CYCLES), .N_DRV(N_DRV),
  .N_RCV(N_RCV)) u_mon (.*);

/* File: tb/sipc_peer.sv */
// partner: remote serial peer plus charge-pump rail stand-in
`timescale 1ns/1ps
module sipc_peer
  import sipc_pkg::*;
#(
  parameter int unsigned N_RCV = 2,
  parameter int unsigned RAIL_CYC = PUMP_CYC // slow rail settling
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pump_en_i,
  input wire logic cable_i,
  input wire logic talk_i,
  output logic [N_RCV-1:0] rcv_in_o,
  output logic [N_RCV-1:0] level_ok_o,
  output logic rail_ok_o
);
  logic [15:0] rail_q; // cycles since pump start
  always_ff @(posedge clk_i) begin
    // rail collapses at once when the pump stops
    if (rst_i || !pump_en_i) rail_q <= '0;
    else if (rail_q != 16'(RAIL_CYC)) rail_q <= rail_q + 16'h0001;
    rail_ok_o <= !rst_i && pump_en_i && rail_q == 16'(RAIL_CYC);
    level_ok_o <= {N_RCV{cable_i}};
    // pull-downs hold an unplugged line at rest
    if (rst_i || !cable_i) rcv_in_o <= '0;
    else if (talk_i) rcv_in_o <= ~rcv_in_o;
  end
endmodule

/* File: tb/sipc_top_bench.sv */
// bench: pin and bus scenarios for the idle power controller
`timescale 1ns/1ps
module sipc_top_bench
  import sipc_pkg::*;
;
  localparam int unsigned IDL = 2000; // short idle interval
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ws_q = 1'b1, sp_q = 1'b1, fb_ws = 1'b0, fb_sp = 1'b0;
  logic cab = 1'b1, talk = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [1:0] drv = 2'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rd, wdo;
  logic [1:0] rin, lok, oe, dout, rout;
  logic rok, lv, rdy, pump, irq, ack;
  int miscompares = 0, n_checks = 0, ncyc = 0, n;
  // rows: wake pin, sleep pin, cable, expect on, expect valid
  logic [4:0] rows [4] = '{5'h1F, 5'h05, 5'h10, 5'h0F};
  always #50 clk_i = ~clk_i;
  sipc_top #(.IDLE_CYCLES(IDL)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .auto_wake_select_i(fb_ws ? lv : ws_q),
    .force_sleep_pin_i(fb_sp ? lv : sp_q),
    .drv_in_i(drv), .rcv_in_i(rin), .rcv_level_ok_i(lok),
    .neg_rail_ok_i(rok), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(wdo), .wb_ack_o(ack), .drv_out_o(dout), .drv_oe_o(oe),
    .rcv_out_o(rout), .line_valid_o(lv), .ready_o(rdy),
    .pump_en_o(pump), .irq_o(irq));
  sipc_peer peer (.clk_i(clk_i), .rst_i(rst_i), .pump_en_i(pump),
    .cable_i(cab), .talk_i(talk), .rcv_in_o(rin), .level_ok_o(lok),
    .rail_ok_o(rok));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one classic cycle; waits for ack, bounded
  task automatic wb(input logic [3:0] a, input logic w,
    input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 16);
    chk("ack", ack, 1'b1);
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    ncyc++;
    if (ncyc == 30000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    cy(5);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      ws_q <= rows[i][4];
      sp_q <= rows[i][3];
      cab <= rows[i][2];
      cy(1);
      drv <= ~drv;
      cy(1100);
      chk("oe", oe, {2{rows[i][1]}});
      chk("pump", pump, rows[i][1]);
      chk("ready", rdy, rows[i][1]);
      chk("valid", lv, rows[i][0]);
      chk("dout", dout, {~drv});
      wb(REG_STAT, 1'b0, 32'h0000_0000);
      chk("stat", rd[1:0], {rows[i][0], rows[i][1]});
    end
    // idle timer restarts on an edge, then expires with line live
    cy(700);
    drv <= ~drv;
    cy(1500);
    chk("restart", oe, 2'h3);
    cy(600);
    chk("idle_oe", oe, 2'h0);
    chk("idle_lv", lv, 1'b1);
    // one receiver edge from the peer wakes the device
    talk <= 1'b1;
    cy(1);
    talk <= 1'b0;
    n = 0;
    do begin
      cy(1);
      n++;
    end while (oe !== 2'h3 && n < 1100);
    chk("wake_time", n >= 995 && n <= 1010, 1'b1);
    chk("rout", rout, {~rin});
    // interrupt on line-valid change, read clears it
    wb(REG_MASK, 1'b1, 32'h0000_0002);
    wb(REG_IRQ, 1'b0, 32'h0000_0000);
    chk("irq_idle", irq, 1'b0);
    cab <= 1'b0;
    cy(320);
    chk("lv_drop", lv, 1'b0);
    chk("irq", irq, 1'b1);
    wb(REG_IRQ, 1'b0, 32'h0000_0000);
    chk("irq_st", rd[1], 1'b1);
    cy(2);
    chk("irq_clr", irq, 1'b0);
    wb(REG_MASK, 1'b0, 32'h0000_0000);
    chk("mask", rd, 32'h0000_0002);
    wb(4'h2, 1'b0, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    // line-valid fed back to the wake pin
    fb_ws <= 1'b1;
    // long enough for the idle interval to run out from here
    cy(2100);
    chk("fb_sleep", oe, 2'h0);
    cab <= 1'b1;
    cy(2100);
    chk("fb_awake", oe, 2'h3);
    // line-valid fed to both pins
    fb_sp <= 1'b1;
    cab <= 1'b0;
    cy(320);
    chk("both_off", pump, 1'b0);
    drv <= ~drv;
    cy(20);
    chk("both_edge", oe, 2'h0);
    cab <= 1'b1;
    cy(1100);
    chk("both_on", oe, 2'h3);
    rst_i <= 1'b1;
    cy(2);
    chk("rst", {oe, pump, rdy, lv, irq, ack}, 32'h0000_0000);
    close_out();
  end
endmodule
